// >>> inc/rtct_map.svh
// Register offsets, field positions, reset values and counts of the trim block
`ifndef RTCT_MAP_SVH
`define RTCT_MAP_SVH

// ----------------------------------------------------------------------
// Serial register space
// ----------------------------------------------------------------------
`define RTCT_ADDR_TRIM 4'h7
`define RTCT_ADDR_CTL1 4'he
`define RTCT_ADDR_CTL2 4'hf

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define RTCT_PON_BIT 4
`define RTCT_TRIM_RST 7'h00
`define RTCT_CTL1_RST 8'h00
`define RTCT_PULSE_MASK 8'hcf
`define RTCT_PULSE_CODE 8'h03
`define RTCT_CMD_FMT_READ 2
`define RTCT_CMD_FMT_SINGLE 3

// ----------------------------------------------------------------------
// Time base in oscillator cycles, step shift, last window second and trim codes
// ----------------------------------------------------------------------
`define RTCT_SEC_CYC 16'h8000
`define RTCT_HALF_SEC_CYC 16'h4000
`define RTCT_STEP_SHIFT 1
`define RTCT_WINDOW_LAST 5'h13
`define RTCT_CODE_ONE 7'h01
`define RTCT_CODE_M63 7'h41

`endif

// >>> inc/rtct_pkg.sv
// Types shared by the trim block and its serial port
package rtct_pkg;

  typedef struct packed {
    logic ce;
    logic sclk;
    logic si;
  } rtct_ser_t;

  typedef struct packed {
    logic stb;
    logic [3:0] addr;
    logic [7:0] data;
  } rtct_wr_t;

endpackage

// >>> verilog/rtct_serial_port.sv
// Four-wire serial port: command byte, then single or burst data bytes
`timescale 1ns/100ps
`include "rtct_map.svh"

module rtct_serial_port (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire rtct_pkg::rtct_ser_t ser_i,
  input wire logic [7:0] rd_data_i,
  output logic [3:0] rd_addr_o,
  output rtct_pkg::rtct_wr_t wr_o,
  output logic so_o
);

  typedef struct packed {
    logic sclk_prev;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic is_cmd;
    logic rd;
    logic burst;
    logic load;
    logic [3:0] addr;
    logic [7:0] sodat;
    logic so;
    rtct_pkg::rtct_wr_t wr;
  } rtct_sp_state_t;

  rtct_sp_state_t st;
  rtct_sp_state_t next_st;
  logic rise;
  logic fall;
  logic [7:0] byte_in;

  assign rise = ser_i.sclk & ~st.sclk_prev;
  assign fall = ~ser_i.sclk & st.sclk_prev;
  assign byte_in = {st.shreg[6:0], ser_i.si};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wr.stb = 1'b0;
    next_st.load = 1'b0;
    next_st.sclk_prev = ser_i.sclk;
    if (st.load) begin
      next_st.sodat = rd_data_i;
    end
    if (!ser_i.ce) begin
      // Dropping the enable ends any transfer at once
      next_st.bitcnt = 3'h0;
      next_st.is_cmd = 1'b1;
      next_st.so = 1'b0;
    end else if (rise) begin
      next_st.shreg = byte_in;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7) begin
        if (st.is_cmd) begin
          next_st.addr = byte_in[7:4];
          next_st.rd = byte_in[`RTCT_CMD_FMT_READ];
          next_st.burst = ~byte_in[`RTCT_CMD_FMT_SINGLE];
          next_st.is_cmd = 1'b0;
          next_st.load = byte_in[`RTCT_CMD_FMT_READ];
        end else begin
          if (!st.rd) begin
            next_st.wr.stb = 1'b1;
            next_st.wr.addr = st.addr;
            next_st.wr.data = byte_in;
          end
          if (st.burst) begin
            // Address wraps from the top of the space back to zero
            next_st.addr = st.addr + 4'h1;
            next_st.load = st.rd;
          end else begin
            next_st.is_cmd = 1'b1;
          end
        end
      end
    end else if (fall && st.rd && !st.is_cmd) begin
      next_st.so = st.sodat[7];
      next_st.sodat = {st.sodat[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.is_cmd <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rd_addr_o = st.addr;
  assign wr_o = st.wr;
  assign so_o = st.so;

endmodule

// >>> verilog/rtct_time_trim.sv
// Time base with 20-second digital trim, trim registers and 1 Hz pulse out
//
// Operation
// - Fixed clock output runs from power-up.
// - Trim alters one second per 20-second window.
// - Low six code bits zero disables trim.
// - Codes 0, +1, -64, -63 change nothing.
// - Positive code slows by code minus one.
// - Negative code speeds by distance below 80h.
// - Slow range 3.05 to 189.2 ppm.
// - Fast range 3.05 to 189.2 ppm.
// - Fixed clock output is never trimmed.
// - Control pattern 0,0,x,x,0,0,1,1 gives 1 Hz pulses.
// - Pulse output shows one altered period per window.
// - Trim register sits at address 7h.
// - Power-up flag clears the trim code.
`timescale 1ns/100ps
`include "rtct_map.svh"

module rtct_time_trim (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic osc_clk_i,
  input wire rtct_pkg::rtct_ser_t ser_i,
  output logic ser_so_o,
  output logic fixed_clock_out_pin_o,
  output logic fixed_clock_out_pin_oe_o,
  output logic interrupt_pin_o,
  output logic interrupt_pin_oe_o,
  output logic sec_tick_o,
  output logic [4:0] window_sec_o
);

  typedef struct packed {
    logic fix_out;
    logic osc_prev;
    logic [15:0] div;
    logic [4:0] win_sec;
    logic sec_tick;
    logic [6:0] trim_value_field;
    logic [7:0] ctl1;
    logic power_up_flag;
    logic pulse_low;
  } rtct_state_t;

  rtct_state_t st;
  rtct_state_t next_st;
  rtct_pkg::rtct_wr_t wr;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic osc_edge;
  logic pulse_mode;
  logic [7:0] steps;
  logic [15:0] period;

  // ----------------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------------
  rtct_serial_port u_port (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ser_i(ser_i),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .wr_o(wr),
    .so_o(ser_so_o)
  );

  always_comb begin
    if (rd_addr == `RTCT_ADDR_TRIM) begin
      rd_data = {1'b0, st.trim_value_field};
    end else if (rd_addr == `RTCT_ADDR_CTL1) begin
      rd_data = st.ctl1;
    end else if (rd_addr == `RTCT_ADDR_CTL2) begin
      rd_data = 8'h00;
      rd_data[`RTCT_PON_BIT] = st.power_up_flag;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Trim code to signed step count
  // ----------------------------------------------------------------------
  function automatic logic [7:0] trim_steps(input logic [6:0] code);
    logic [7:0] s;
    s = 8'h00;
    if (code[5:0] == 6'h00) begin
      s = 8'h00;
    end else if (code == `RTCT_CODE_ONE || code == `RTCT_CODE_M63) begin
      s = 8'h00;
    end else if (!code[6]) begin
      s = {1'b0, code} - 8'h01;
    end else begin
      // Sign-extended code is minus its distance below 80h
      s = {1'b1, code};
    end
    return s;
  endfunction

  assign steps = trim_steps(st.trim_value_field);

  // Each step is two oscillator cycles so one step per window is ~3.05 ppm
  always_comb begin
    if (st.win_sec == 5'h00) begin
      period = `RTCT_SEC_CYC
        + ({{8{steps[7]}}, steps} <<< `RTCT_STEP_SHIFT);
    end else begin
      period = `RTCT_SEC_CYC;
    end
  end

  assign osc_edge = osc_clk_i & ~st.osc_prev;
  assign pulse_mode =
    (st.ctl1 & `RTCT_PULSE_MASK) == `RTCT_PULSE_CODE;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.osc_prev = osc_clk_i;
    next_st.sec_tick = 1'b0;
    // Straight copy of the crystal; trim never reaches this pin
    next_st.fix_out = osc_clk_i;
    if (osc_edge) begin
      // Compare with >= so a code change mid-second cannot overrun
      if (st.div >= period - 16'h0001) begin
        next_st.div = 16'h0000;
        next_st.sec_tick = 1'b1;
        if (st.win_sec == `RTCT_WINDOW_LAST) begin
          next_st.win_sec = 5'h00;
        end else begin
          next_st.win_sec = st.win_sec + 5'h01;
        end
      end else begin
        next_st.div = st.div + 16'h0001;
      end
    end
    // Low for the first half of each second, so the trimmed
    // second shows as one altered pulse period per window
    next_st.pulse_low = pulse_mode
      && (next_st.div < `RTCT_HALF_SEC_CYC);
    if (wr.stb) begin
      if (wr.addr == `RTCT_ADDR_TRIM) begin
        // Top bit of the byte is dropped
        next_st.trim_value_field = wr.data[6:0];
      end else if (wr.addr == `RTCT_ADDR_CTL1) begin
        next_st.ctl1 = wr.data;
      end else if (wr.addr == `RTCT_ADDR_CTL2) begin
        // Flag accepts only a written zero
        if (!wr.data[`RTCT_PON_BIT]) begin
          next_st.power_up_flag = 1'b0;
        end
      end
    end
    if (st.power_up_flag) begin
      next_st.trim_value_field = `RTCT_TRIM_RST;
      next_st.ctl1 = `RTCT_CTL1_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.power_up_flag <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Pins: both are open drain, enable high while pulling low
  // ----------------------------------------------------------------------
  assign fixed_clock_out_pin_o = 1'b0;
  assign fixed_clock_out_pin_oe_o = ~st.fix_out;
  assign interrupt_pin_o = 1'b0;
  assign interrupt_pin_oe_o = st.pulse_low;
  assign sec_tick_o = st.sec_tick;
  assign window_sec_o = st.win_sec;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_fixed_untrimmed;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 (fixed_clock_out_pin_oe_o == ~$past(osc_clk_i));
  endproperty
  a_fixed_untrimmed: assert property (p_fixed_untrimmed)
    else $error("Fixed clock output does not follow the crystal");

  property p_disabled;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st.trim_value_field[5:0] == 6'h00) |-> (period == 16'h8000);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Trim active with zero low code bits");

  property p_no_change;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st.trim_value_field == 7'h01 || st.trim_value_field == 7'h40
       || st.trim_value_field == 7'h41) |-> (period == 16'h8000);
  endproperty
  a_no_change: assert property (p_no_change)
    else $error("No-change code altered the second");

  property p_slow;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st.win_sec == 5'h00 && !st.trim_value_field[6]
       && st.trim_value_field > 7'h01)
      |-> (period == 16'h8000 + 16'(2 * (st.trim_value_field - 7'h01)));
  endproperty
  a_slow: assert property (p_slow)
    else $error("Positive code gave the wrong longer second");

  property p_fast;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st.win_sec == 5'h00 && st.trim_value_field > 7'h41)
      |-> (period == 16'h8000 - 16'(2 * (8'h80 - st.trim_value_field)));
  endproperty
  a_fast: assert property (p_fast)
    else $error("Negative code gave the wrong shorter second");

  property p_range;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (period >= 16'h7f84) && (period <= 16'h807c);
  endproperty
  a_range: assert property (p_range)
    else $error("Second length outside the trim range");

  property p_window;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st.win_sec != 5'h00) |-> (period == 16'h8000);
  endproperty
  a_window: assert property (p_window)
    else $error("Second outside the window start was trimmed");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      sec_tick_o |-> (st.div == 16'h0000) && (window_sec_o ==
        (($past(window_sec_o) == 5'h13) ? 5'h00
         : 5'($past(window_sec_o) + 5'h01)));
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Window second did not step or wrap at the tick");

  property p_pon_clears;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      st.power_up_flag |=> (st.trim_value_field == 7'h00);
  endproperty
  a_pon_clears: assert property (p_pon_clears)
    else $error("Trim code survived the power-up flag");

  property p_trim_write;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (wr.stb && wr.addr == 4'h7 && !st.power_up_flag)
      |=> (st.trim_value_field == $past(wr.data[6:0]));
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("Write to address 7h not stored");

  property p_pulse_gated;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      interrupt_pin_oe_o |-> $past(pulse_mode) || $past(st.power_up_flag);
  endproperty
  a_pulse_gated: assert property (p_pulse_gated)
    else $error("Pulse output without the pulse-mode pattern");

  property p_win_range;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      window_sec_o <= 5'h13;
  endproperty
  a_win_range: assert property (p_win_range)
    else $error("Window second beyond the last of twenty");

  property p_tick_single;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      sec_tick_o |=> !sec_tick_o;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("Second tick lasted more than one cycle");

  property p_div_bound;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      st.div < 16'h807c;
  endproperty
  a_div_bound: assert property (p_div_bound)
    else $error("Divider ran past the longest trimmed second");

  property p_pulse_half;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      interrupt_pin_oe_o |-> (st.div < 16'h4000);
  endproperty
  a_pulse_half: assert property (p_pulse_half)
    else $error("Pulse output low outside the first half second");

  property p_trim_top_zero;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (rd_addr == 4'h7) |-> (rd_data[7] == 1'b0);
  endproperty
  a_trim_top_zero: assert property (p_trim_top_zero)
    else $error("Trim register read a set top bit");

endmodule

// >>> verification/rtct_host_model.sv
// Host CPU model driving the four-wire serial port of the trim block
`timescale 1ns/100ps

module rtct_host_model (
  input wire logic sys_clk_i,
  input wire logic so_i,
  output rtct_pkg::rtct_ser_t ser_o
);
  initial begin
    ser_o = '0;
  end

  // One bit per 8 cycles, MSB first; so is taken before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      rx[i] = so_i;
      ser_o.si = tx[i];
      ser_o.sclk = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      ser_o.sclk = 1'b0;
      repeat (4) @(negedge sys_clk_i);
    end
    // Idle data line shows the inverse, never a stale bit
    ser_o.si = ~tx[0];
  endtask

  // Single-byte format: command, then one data byte, then ce low
  task automatic access(input logic [3:0] addr, input logic rd,
                        input logic [7:0] wd, output logic [7:0] rdat);
    logic [7:0] junk;
    @(negedge sys_clk_i);
    ser_o.ce = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    xfer({addr, 1'b1, rd, 2'b00}, junk);
    xfer(wd, rdat);
    ser_o.ce = 1'b0;
    repeat (8) @(negedge sys_clk_i);
  endtask

  // Burst format: command, then two bytes at rising addresses
  task automatic burst(input logic [3:0] addr, input logic rd,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [7:0] junk;
    @(negedge sys_clk_i);
    ser_o.ce = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    xfer({addr, 1'b0, rd, 2'b00}, junk);
    xfer(wd[15:8], rdat[15:8]);
    xfer(wd[7:0], rdat[7:0]);
    ser_o.ce = 1'b0;
    repeat (8) @(negedge sys_clk_i);
  endtask
endmodule

// >>> verification/rtct_time_trim_tb_top.sv
// Self-checking bench of the trim block: registers, reset, trimmed second
`timescale 1ns/100ps
`include "rtct_map.svh"

module rtct_time_trim_tb_top;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic osc_clk_i = 1'b0;
  rtct_pkg::rtct_ser_t ser;
  logic so, fix_d, fix_oe, irq_d, irq_oe, tick;
  logic [4:0] win;
  logic oe_bad = 1'b0;
  logic irq_early, irq_late;
  logic [15:0] bx;
  int fails = 0;
  int comparisons = 0;
  int n, exp_len;
  logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h41, 8'h40, 8'h3f, 8'h7f, 8'h42};

  always #12.5 sys_clk_i = ~sys_clk_i;

  rtct_time_trim rtct_time_trim_i (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .osc_clk_i(osc_clk_i),
    .ser_i(ser),
    .ser_so_o(so),
    .fixed_clock_out_pin_o(fix_d),
    .fixed_clock_out_pin_oe_o(fix_oe),
    .interrupt_pin_o(irq_d),
    .interrupt_pin_oe_o(irq_oe),
    .sec_tick_o(tick),
    .window_sec_o(win)
  );

  rtct_host_model rtct_host_model_i (
    .sys_clk_i(sys_clk_i),
    .so_i(so),
    .ser_o(ser)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] x;
    rtct_host_model_i.access(a, 1'b0, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] exp);
    logic [7:0] x;
    rtct_host_model_i.access(a, 1'b1, 8'ha5, x);
    cmp8(what, exp, x);
  endtask

  task automatic burst_chk(input string what, input logic [3:0] a,
                           input logic [15:0] exp);
    logic [15:0] x;
    rtct_host_model_i.burst(a, 1'b1, 16'h0000, x);
    cmp8({what, " first"}, exp[15:8], x[15:8]);
    cmp8({what, " second"}, exp[7:0], x[7:0]);
  endtask

  task automatic do_reset();
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    do_reset();
    cmp8("pulse enable after reset", 8'h00, {7'h00, irq_oe});
    cmp8("pin data", 8'h00, {6'h00, fix_d, irq_d});
    rd_chk("trim after reset", 4'h7, 8'h00);
    rd_chk("flag after reset", 4'hf, 8'h10);
    wr(4'h7, 8'h09);
    rd_chk("trim held by flag", 4'h7, 8'h00);
    rd_chk("unmapped address", 4'h3, 8'h00);
    wr(4'hf, 8'h00);
    rd_chk("flag cleared", 4'hf, 8'h00);
    $display("test power_up done");
    // Disable and no-change codes among them
    foreach (codes[i]) begin
      wr(4'h7, codes[i]);
      rd_chk("trim readback", 4'h7, codes[i]);
    end
    wr(4'h7, 8'h89);
    rd_chk("trim top bit", 4'h7, 8'h09);
    // Burst from 6h: first byte is dropped, second lands in trim
    rtct_host_model_i.burst(4'h6, 1'b0, 16'h553a, bx);
    rd_chk("trim burst write", 4'h7, 8'h3a);
    burst_chk("burst read", 4'h6, 16'h003a);
    $display("test trim_register done");
    do_reset();
    rd_chk("trim after second reset", 4'h7, 8'h00);
    wr(4'hf, 8'h00);
    // Don't-care bits of the pattern set; pulse mode must still start
    wr(4'he, 8'h33);
    rd_chk("control pulse mode", 4'he, 8'h33);
    wr(4'h7, 8'h46);
    $display("test setup done");
    // Oscillator held still until now, so second 0 has a known edge count;
    // no host access falls inside the measured second
    exp_len = int'(`RTCT_SEC_CYC) + 2 * (int'(8'h46) - 128);
    n = 0;
    forever begin
      @(negedge sys_clk_i);
      if (tick === 1'b1 || n > 34000) break;
      if (fix_oe !== ~osc_clk_i) oe_bad = 1'b1;
      if (n == 200) irq_early = irq_oe;
      if (n == exp_len - 50) irq_late = irq_oe;
      osc_clk_i = ~osc_clk_i;
      if (osc_clk_i) n++;
    end
    // Tick shows on the edge after the closing rise: no slack allowed
    cmp8("second length", 8'h00, 8'(n - exp_len));
    cmp8("fixed clock follows osc", 8'h00, {7'h00, oe_bad});
    cmp8("pulse halves differ", 8'h01, {7'h00, irq_early ^ irq_late});
    repeat (2) @(negedge sys_clk_i);
    cmp8("window second", 8'h01, {3'h0, win});
    $display("test trimmed_second done");
    close_out();
  end
endmodule
